// file: core/fzc_freeze_ctrl.sv
// freeze mode entry control, pin-only and gated variants
// assumes pin and permit synchronous to ref_clk, APB master outside
`timescale 1ns/10ps
module fzc_freeze_ctrl
    import fzc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // freeze request and permit
    input wire logic freeze_request_pin_n,
    input wire logic freeze_entry_permit,
    input wire logic freeze_entry_permit_primitive,
    // register bus
    input wire fzc_apb_req_t apb_req,
    output fzc_apb_rsp_t apb_rsp,
    // freeze effects
    output logic freeze_active,
    output logic pad_oe_mask,
    output logic core_in_high
);
    // ************************************************************
    // state
    // ************************************************************
    fzc_state_t s_q;
    fzc_state_t s_d;
    logic pin_asserted;
    logic permit_asserted;
    logic enter_ok;
    logic apb_access;

    always_comb begin
        pin_asserted = ~freeze_request_pin_n;
        // permit counts only with the primitive and gated mode
        permit_asserted = s_q.gated & freeze_entry_permit_primitive
            & (freeze_entry_permit | s_q.permit);
        enter_ok = s_q.gated ? (pin_asserted & permit_asserted)
            : pin_asserted;
        apb_access = apb_req.psel & apb_req.penable;
        s_d = s_q;
        s_d.rsp.pready = 1'b0;
        s_d.rsp.pslverr = 1'b0;
        s_d.rsp.prdata = 32'h0000_0000;
        unique case (s_q.mode)
            FZC_RUN: begin
                if (enter_ok) begin
                    s_d.mode = FZC_FROZEN;
                end
            end
            FZC_FROZEN: begin
                // exit on pin release only; permit drop does not wake
                if (!pin_asserted) begin
                    s_d.mode = FZC_RUN;
                end
            end
            default: begin
                s_d.mode = FZC_RUN;
            end
        endcase
        s_d.frozen = (s_d.mode == FZC_FROZEN);
        s_d.pad_oe_mask = s_d.frozen;
        s_d.core_in_high = s_d.frozen;
        // ********************************************************
        // apb slave, one wait state, answer on second access cycle
        // ********************************************************
        if (apb_access && !s_q.rsp.pready) begin
            s_d.rsp.pready = 1'b1;
            if (apb_req.paddr == FZC_CTRL_OFS) begin
                if (apb_req.pwrite) begin
                    s_d.gated = apb_req.pwdata[FZC_CTRL_GATED_BIT];
                    s_d.permit = apb_req.pwdata[FZC_CTRL_PERMIT_BIT];
                end else begin
                    s_d.rsp.prdata[FZC_CTRL_GATED_BIT] = s_q.gated;
                    s_d.rsp.prdata[FZC_CTRL_PERMIT_BIT] = s_q.permit;
                end
            end else if (apb_req.paddr == FZC_STAT_OFS) begin
                if (apb_req.pwrite) begin
                    s_d.rsp.pslverr = 1'b1;
                end else begin
                    s_d.rsp.prdata[FZC_STAT_FROZEN_BIT] = s_q.frozen;
                    s_d.rsp.prdata[FZC_STAT_PIN_BIT] = pin_asserted;
                    s_d.rsp.prdata[FZC_STAT_PERMIT_BIT] = permit_asserted;
                    s_d.rsp.prdata[FZC_STAT_GATED_BIT] = s_q.gated;
                end
            end else begin
                s_d.rsp.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q.mode <= FZC_RUN;
            s_q.gated <= FZC_GATED_RST;
            s_q.permit <= FZC_PERMIT_RST;
            s_q.frozen <= 1'b0;
            s_q.pad_oe_mask <= 1'b0;
            s_q.core_in_high <= 1'b0;
            s_q.rsp <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs straight from flops
    // ************************************************************
    assign apb_rsp = s_q.rsp;
    assign freeze_active = s_q.frozen;
    assign pad_oe_mask = s_q.pad_oe_mask;
    assign core_in_high = s_q.core_in_high;

    // ************************************************************
    // checks
    // ************************************************************
    gated_needs_both_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (s_q.gated && !(pin_asserted && permit_asserted) && !s_q.frozen)
        |=> !s_q.frozen)
        else $error("gated freeze entered without pin and permit");
    gated_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (s_q.gated && pin_asserted && permit_asserted) |=> s_q.frozen)
        else $error("gated freeze not entered");
    pin_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (s_q.frozen && freeze_request_pin_n) |=> !s_q.frozen)
        else $error("freeze not left on pin release");
    pin_only_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!s_q.gated && $stable(s_q.gated)) |=> (s_q.frozen == !$past(freeze_request_pin_n)))
        else $error("pin-only freeze does not follow pin");
    permit_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (s_q.frozen && pin_asserted && !permit_asserted) |=> s_q.frozen)
        else $error("permit drop woke the device");
    pad_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pad_oe_mask == freeze_active)
        else $error("pad mask differs from freeze state");
    core_high_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        core_in_high == freeze_active)
        else $error("core inputs not held high in freeze");
    apb_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (apb_req.psel && apb_req.penable && !apb_rsp.pready) |=> apb_rsp.pready)
        else $error("apb answer late");

    // ************************************************************
    // bus, status and freeze mode checks
    // ************************************************************
    // a held ready would let one access count twice
    ready_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        apb_rsp.pready
        |=> !apb_rsp.pready)
        else $error("apb ready held too long");
    ready_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !(apb_req.psel && apb_req.penable)
        |=> !apb_rsp.pready)
        else $error("apb ready without access");
    stat_write_err_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (apb_access && !apb_rsp.pready && apb_req.pwrite && apb_req.paddr == FZC_STAT_OFS)
        |=> apb_rsp.pslverr)
        else $error("status write not refused");
    unmapped_err_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (apb_access && !apb_rsp.pready && apb_req.paddr != FZC_CTRL_OFS && apb_req.paddr != FZC_STAT_OFS)
        |=> apb_rsp.pslverr)
        else $error("unmapped access not refused");
    ctrl_no_err_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (apb_access && !apb_rsp.pready && apb_req.paddr == FZC_CTRL_OFS)
        |=> !apb_rsp.pslverr)
        else $error("control access refused");
    ctrl_gated_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (apb_access && !apb_rsp.pready && apb_req.pwrite && apb_req.paddr == FZC_CTRL_OFS)
        |=> (s_q.gated == $past(apb_req.pwdata[FZC_CTRL_GATED_BIT])))
        else $error("variant bit not written");
    ctrl_permit_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (apb_access && !apb_rsp.pready && apb_req.pwrite && apb_req.paddr == FZC_CTRL_OFS)
        |=> (s_q.permit == $past(apb_req.pwdata[FZC_CTRL_PERMIT_BIT])))
        else $error("soft permit bit not written");
    stat_frozen_rd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (apb_access && !apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == FZC_STAT_OFS)
        |=> (apb_rsp.prdata[FZC_STAT_FROZEN_BIT] == $past(s_q.frozen)))
        else $error("status frozen bit wrong");
    stat_gated_rd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (apb_access && !apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == FZC_STAT_OFS)
        |=> (apb_rsp.prdata[FZC_STAT_GATED_BIT] == $past(s_q.gated)))
        else $error("status variant bit wrong");
    rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !apb_rsp.pready
        |-> (apb_rsp.prdata == 32'h0000_0000))
        else $error("read data outside answer");
    no_prim_permit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !freeze_entry_permit_primitive
        |-> !permit_asserted)
        else $error("permit counted without primitive");
    freeze_needs_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(freeze_active)
        |-> $past(pin_asserted))
        else $error("freeze entered without pin");
    mode_frozen_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_q.mode == FZC_FROZEN
        |-> s_q.frozen)
        else $error("status differs from mode");
    ungated_permit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!s_q.gated && !s_q.frozen && !pin_asserted)
        |=> !s_q.frozen)
        else $error("pin-only freeze without pin");
    mode_onehot_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        1'b1
        |-> $onehot(s_q.mode))
        else $error("mode code illegal");
endmodule // fzc_freeze_ctrl

// file: core/fzc_pkg.sv
// package for the freeze mode entry control block
// assumes a single 10 MHz clock and an APB master outside
package fzc_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] FZC_CTRL_OFS = 12'h000;
    localparam logic [11:0] FZC_STAT_OFS = 12'h004;
    localparam int FZC_CTRL_GATED_BIT = 0;
    localparam int FZC_CTRL_PERMIT_BIT = 1;
    localparam int FZC_STAT_FROZEN_BIT = 0;
    localparam int FZC_STAT_PIN_BIT = 1;
    localparam int FZC_STAT_PERMIT_BIT = 2;
    localparam int FZC_STAT_GATED_BIT = 3;
    localparam logic FZC_GATED_RST = 1'b0;
    localparam logic FZC_PERMIT_RST = 1'b0;
    // ************************************************************
    // state and carriers
    // ************************************************************
    typedef enum logic [1:0] {
        FZC_RUN = 2'b01,
        FZC_FROZEN = 2'b10
    } fzc_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fzc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fzc_apb_rsp_t;

    typedef struct packed {
        fzc_mode_t mode;
        logic gated;
        logic permit;
        logic frozen;
        logic pad_oe_mask;
        logic core_in_high;
        fzc_apb_rsp_t rsp;
    } fzc_state_t;
endpackage

// file: test/fzc_user_model.sv
// user control logic and external freeze request source
// assumes commands from the bench, changed just after ref_clk rises
`timescale 1ns/10ps
module fzc_user_model (
    // clock
    input wire logic ref_clk,
    // commands from the bench
    input wire logic ask,
    input wire logic safe,
    // freeze link
    output logic freeze_request_pin_n,
    output logic freeze_entry_permit
);
    // ************************************************************
    // drive pin and permit
    // ************************************************************
    // permit waits for safe, so pin may stand alone for a while
    always_ff @(posedge ref_clk) begin
        freeze_request_pin_n <= ~ask;
        freeze_entry_permit <= safe;
    end
endmodule // fzc_user_model

// file: test/tb_top.sv
// bench for the freeze mode entry control block
// assumes the user model file and the design package
`timescale 1ns/10ps
module tb_top
    import fzc_pkg::*;
;
    // ************************************************************
    // stimulus and wiring
    // ************************************************************
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ask = 1'b0;
    logic safe = 1'b0;
    logic prim = 1'b0;
    logic pin_n, permit, fa, oe, hi, e;
    logic [31:0] r;
    fzc_apb_req_t req = '0;
    fzc_apb_rsp_t rsp;
    int fails = 0;
    int checked = 0;
    always #50 ref_clk = ~ref_clk;
    fzc_user_model user (.ref_clk(ref_clk), .ask(ask), .safe(safe),
        .freeze_request_pin_n(pin_n), .freeze_entry_permit(permit));
    fzc_freeze_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .freeze_request_pin_n(pin_n),
        .freeze_entry_permit(permit), .freeze_entry_permit_primitive(prim),
        .apb_req(req), .apb_rsp(rsp), .freeze_active(fa), .pad_oe_mask(oe),
        .core_in_high(hi));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            fails++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, x);
        end
    endtask
    // two edges of model and design latency plus one spare edge before looking
    task automatic fz(input logic a, input logic s, input logic x);
        ask <= a;
        safe <= s;
        repeat (3) @(posedge ref_clk);
        #1 cmp({29'h0, fa, oe, hi}, {29'h0, x, x, x});
        @(posedge ref_clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            fails++;
            $display("CHECK FAILED %0t apb answer missing", $time);
        end
        r = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic report_and_stop;
        $display("fails %0d checked %0d", fails, checked);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, FZC_CTRL_OFS, 32'h0); cmp(r, 32'h0);
        fz(1'b1, 1'b0, 1'b1);
        rst_b <= 1'b0;
        @(posedge ref_clk);
        #1 cmp({29'h0, fa, oe, hi}, 32'h0);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        fz(1'b1, 1'b1, 1'b1);
        fz(1'b0, 1'b1, 1'b0);
        apb(1'b1, FZC_CTRL_OFS, 32'h1);
        prim <= 1'b1;
        fz(1'b0, 1'b1, 1'b0);
        fz(1'b1, 1'b0, 1'b0);
        apb(1'b0, FZC_STAT_OFS, 32'h0); cmp(r, 32'hA);
        fz(1'b1, 1'b1, 1'b1);
        apb(1'b0, FZC_STAT_OFS, 32'h0); cmp(r, 32'hF);
        fz(1'b1, 1'b0, 1'b1);
        fz(1'b0, 1'b0, 1'b0);
        fz(1'b1, 1'b0, 1'b0);
        apb(1'b1, FZC_CTRL_OFS, 32'h3);
        apb(1'b0, FZC_CTRL_OFS, 32'h0); cmp(r, 32'h3);
        fz(1'b1, 1'b0, 1'b1);
        fz(1'b0, 1'b0, 1'b0);
        apb(1'b1, FZC_CTRL_OFS, 32'h1);
        prim <= 1'b0;
        fz(1'b1, 1'b1, 1'b0);
        fz(1'b0, 1'b0, 1'b0);
        apb(1'b1, FZC_STAT_OFS, 32'h1); cmp({31'h0, e}, 32'h1);
        apb(1'b0, 12'h008, 32'h0); cmp({31'h0, e}, 32'h1);
        report_and_stop();
    end
    // runs far longer than the scenarios need
    initial begin
        repeat (2000) @(posedge ref_clk);
        fails++;
        report_and_stop();
    end
endmodule // tb_top
